// >>> hw/cmpr_pkg.sv
// constants, field layout and types for comparator and reference control
//
// What this block does
// - Enable bit 15 switches a comparator; other control fields are kept.
// - Output-enable bit 14 drives the result onto the comparator pin.
// - Inversion bit 13 inverts the result before it leaves the block.
// - Inverted result also feeds the edge detector, flipping the interrupt edge.
// - Read-only bit 8 of each control word shows the live result.
// - Edge field: 11 both, 10 falling, 01 rising, 00 no events.
// - Bit 4 picks ladder reference or pin A for the positive input.
// - Negative select: 11 absolute reference, 10 pin D, 01 pin C, 00 pin B.
// - Unimplemented bits ignore writes and read as zero.
// - Stop-in-idle bit 13 disables all comparators while the device idles.
// - Status word bits 2,1,0 mirror results of comparators 3,2,1.
// - Ladder has two ranges of sixteen levels chosen by a four-bit tap.
// - Ladder control at 0x9800 resets to zero; enable bit 15 plus low fields.
// - Clear, set and invert aliases sit at +0x4, +0x8, +0xc.
// - Cleared ladder enable powers the ladder down.
// - Ladder bit 6 connects the ladder voltage to its pin.
// - Range bit: one gives span/24 from zero, zero span/32 from a quarter.
// - Source bit 4: external reference pins when one, supply rails when zero.
package cmpr_pkg;

  localparam int unsigned NUM_CMP = 3;

  // ----------------------------------------------------------------
  // addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] LADDER_CTL_ADDR = 16'h9800;
  localparam logic [15:0] CMP_CTL_ADDR0   = 16'ha000;
  localparam logic [15:0] CMP_CTL_STRIDE  = 16'h0010;
  localparam logic [15:0] STATUS_ADDR     = 16'ha060;

  // alias operation from address bits 3:2
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CLEAR = 2'h1;
  localparam logic [1:0] OP_SET   = 2'h2;
  localparam logic [1:0] OP_INV   = 2'h3;

  // ----------------------------------------------------------------
  // comparator control fields
  // ----------------------------------------------------------------
  localparam int unsigned ON_BIT      = 15;
  localparam int unsigned PIN_OE_BIT  = 14;
  localparam int unsigned INVERT_BIT  = 13;
  localparam int unsigned RESULT_BIT  = 8;
  localparam int unsigned EDGE_LSB    = 6;
  localparam int unsigned POS_SEL_BIT = 4;
  localparam int unsigned NEG_LSB     = 0;
  localparam logic [15:0] CMP_CTL_MASK  = 16'he0d3;
  localparam logic [15:0] CMP_CTL_RESET = 16'h00c3;

  // event edge encodings
  localparam logic [1:0] EDGE_OFF     = 2'h0;
  localparam logic [1:0] EDGE_RISING  = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;

  // ----------------------------------------------------------------
  // status and ladder fields
  // ----------------------------------------------------------------
  localparam int unsigned STOP_IDLE_BIT = 13;
  localparam logic [15:0] STATUS_MASK   = 16'h2000;
  localparam logic        STATUS_RESET  = 1'b0;

  localparam int unsigned LADDER_EN_BIT     = 15;
  localparam int unsigned LADDER_PIN_OE_BIT = 6;
  localparam int unsigned LADDER_RANGE_BIT  = 5;
  localparam int unsigned LADDER_SRC_BIT    = 4;
  localparam int unsigned LADDER_TAP_LSB    = 0;
  localparam logic [15:0] LADDER_MASK       = 16'h807f;
  localparam logic [15:0] LADDER_RESET      = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {BUS_IDLE, BUS_ANSWER} cmpr_bus_state_t;

  typedef struct packed {
    logic [NUM_CMP-1:0][15:0] cmp_ctl;
    logic                     stop_in_idle;
    logic [15:0]              ladder_ctl;
    cmpr_bus_state_t          bus_state;
    logic [31:0]              rdata;
  } cmpr_state_t;

  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic level;
    logic was_active;
    logic event_pulse;
  } cmpr_edge_state_t;

endpackage : cmpr_pkg

// >>> hw/cmpr_edge.sv
// one comparator channel: synchroniser, inversion, gating and edge events
module cmpr_edge (
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  input  wire logic       raw_in,
  input  wire logic       active_in,
  input  wire logic       invert_in,
  input  wire logic [1:0] edge_sel_in,
  output logic            level_out,
  output logic            event_out
);
  import cmpr_pkg::*;

  cmpr_edge_state_t st_reg;
  cmpr_edge_state_t st_next;
  logic             shown;
  logic             rise;
  logic             fall;

  always_comb begin
    st_next             = st_reg;
    st_next.sync_first  = raw_in;
    st_next.sync_second = st_reg.sync_first;
    shown               = active_in & (st_reg.sync_second ^ invert_in);
    rise                = shown & ~st_reg.level;
    fall                = ~shown & st_reg.level;
    st_next.level       = shown;
    st_next.was_active  = active_in;
    // no events across an enable change
    case (edge_sel_in)
      EDGE_RISING:  st_next.event_pulse = active_in & st_reg.was_active & rise;
      EDGE_FALLING: st_next.event_pulse = active_in & st_reg.was_active & fall;
      EDGE_BOTH:    st_next.event_pulse = active_in & st_reg.was_active & (rise | fall);
      default:      st_next.event_pulse = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;
  assign event_out = st_reg.event_pulse;

endmodule : cmpr_edge

// >>> hw/cmpr_ctrl.sv
// comparator and reference ladder control with avalon register slave
//
// The Avalon-MM interface to the registers was chosen for this implementation.
module cmpr_ctrl (
  input  wire logic                                  mclk_in,
  input  wire logic                                  reset_in,
  input  wire logic                                  ce_in,
  // register bus
  input  wire logic [15:0]                           avs_address_in,
  input  wire logic                                  avs_read_in,
  input  wire logic                                  avs_write_in,
  input  wire logic [31:0]                           avs_writedata_in,
  input  wire logic [3:0]                            avs_byteenable_in,
  output logic      [31:0]                           avs_readdata_out,
  output logic                                       avs_waitrequest_out,
  // device power state
  input  wire logic                                  idle_mode_in,
  // analog comparator cores
  input  wire logic [cmpr_pkg::NUM_CMP-1:0]          cmp_raw_in,
  output logic      [cmpr_pkg::NUM_CMP-1:0]          cmp_enable_out,
  output logic      [cmpr_pkg::NUM_CMP-1:0]          positive_input_select_out,
  output logic      [cmpr_pkg::NUM_CMP-1:0][1:0]     negative_input_select_out,
  // comparator pins and events
  output logic      [cmpr_pkg::NUM_CMP-1:0]          comparator_output_pin_out,
  output logic      [cmpr_pkg::NUM_CMP-1:0]          comparator_output_pin_oe_out,
  output logic      [cmpr_pkg::NUM_CMP-1:0]          cmp_event_out,
  // reference ladder
  output logic                                       ladder_enable_out,
  output logic                                       ladder_pin_output_enable_out,
  output logic                                       ladder_range_select_out,
  output logic                                       ladder_source_select_out,
  output logic      [3:0]                            ladder_tap_value_out
);
  import cmpr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cmpr_state_t              st_reg;
  cmpr_state_t              st_next;
  logic [NUM_CMP-1:0]       active;
  logic [NUM_CMP-1:0]       level;
  logic                     request;
  logic [1:0]               op;
  logic [15:0]              lane_mask;
  logic [15:0]              wdata;
  logic                     hit_ladder;
  logic                     hit_status;
  logic [NUM_CMP-1:0]       hit_cmp;
  logic [31:0]              read_word;
  logic [15:0]              stat_word;

  // ----------------------------------------------------------------
  // alias write helper
  // ----------------------------------------------------------------
  function automatic logic [15:0] apply_write(
    input logic [15:0] old_val,
    input logic [15:0] wd,
    input logic [1:0]  kind,
    input logic [15:0] mask
  );
    logic [15:0] val;
    val = old_val;
    case (kind)
      OP_CLEAR: val = old_val & ~wd;
      OP_SET:   val = old_val | wd;
      OP_INV:   val = old_val ^ wd;
      default:  val = (old_val & ~lane_mask) | wd;
    endcase
    // only implemented bits can change
    apply_write = (old_val & ~mask) | (val & mask);
  endfunction : apply_write

  // ----------------------------------------------------------------
  // comparator channels
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      assign active[gi] = st_reg.cmp_ctl[gi][ON_BIT]
                        & ~(st_reg.stop_in_idle & idle_mode_in);
      cmpr_edge u_edge (
        .mclk_in     (mclk_in),
        .reset_in    (reset_in),
        .ce_in       (ce_in),
        .raw_in      (cmp_raw_in[gi]),
        .active_in   (active[gi]),
        .invert_in   (st_reg.cmp_ctl[gi][INVERT_BIT]),
        .edge_sel_in (st_reg.cmp_ctl[gi][EDGE_LSB+1:EDGE_LSB]),
        .level_out   (level[gi]),
        .event_out   (cmp_event_out[gi])
      );
      assign hit_cmp[gi] = avs_address_in[15:4]
                         == 12'(({4'h0, CMP_CTL_ADDR0[15:4]} + 16'(gi)) & 16'h0fff);
      assign positive_input_select_out[gi] = st_reg.cmp_ctl[gi][POS_SEL_BIT];
      assign negative_input_select_out[gi] = st_reg.cmp_ctl[gi][NEG_LSB+1:NEG_LSB];
      assign comparator_output_pin_out[gi] = level[gi];
      assign comparator_output_pin_oe_out[gi] = st_reg.cmp_ctl[gi][PIN_OE_BIT]
                                              & active[gi];
    end
  endgenerate

  assign cmp_enable_out = active;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign request    = avs_read_in | avs_write_in;
  assign op         = avs_address_in[3:2];
  assign hit_ladder = avs_address_in[15:4] == LADDER_CTL_ADDR[15:4];
  assign hit_status = avs_address_in[15:4] == STATUS_ADDR[15:4];
  assign lane_mask  = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wdata      = avs_writedata_in[15:0] & lane_mask;

  // read value of the base word; aliases and unmapped read zero
  always_comb begin
    read_word = '0;
    if (op == OP_WRITE && avs_address_in[1:0] == 2'h0) begin
      if (hit_ladder) begin
        read_word[15:0] = st_reg.ladder_ctl & LADDER_MASK;
      end else if (hit_status) begin
        read_word[STOP_IDLE_BIT] = st_reg.stop_in_idle;
        read_word[NUM_CMP-1:0]   = level;
      end else begin
        for (int i = 0; i < NUM_CMP; i++) begin
          if (hit_cmp[i]) begin
            read_word[15:0]       = st_reg.cmp_ctl[i] & CMP_CTL_MASK;
            read_word[RESULT_BIT] = level[i];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // next state and bus sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_next   = st_reg;
    stat_word = apply_write({2'h0, st_reg.stop_in_idle, 13'h0000}, wdata, op, STATUS_MASK);
    case (st_reg.bus_state)
      BUS_IDLE: begin
        if (request) begin
          st_next.rdata     = avs_read_in ? read_word : 32'h0000_0000;
          st_next.bus_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        st_next.bus_state = BUS_IDLE;
        if (avs_write_in && avs_address_in[1:0] == 2'h0) begin
          if (hit_ladder) begin
            st_next.ladder_ctl = apply_write(st_reg.ladder_ctl, wdata, op, LADDER_MASK);
          end else if (hit_status) begin
            st_next.stop_in_idle = stat_word[STOP_IDLE_BIT];
          end else begin
            for (int i = 0; i < NUM_CMP; i++) begin
              if (hit_cmp[i]) begin
                st_next.cmp_ctl[i] = apply_write(st_reg.cmp_ctl[i], wdata, op,
                                                 CMP_CTL_MASK);
              end
            end
          end
        end
      end
      default: begin
        st_next.bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_reg.cmp_ctl      <= {NUM_CMP{CMP_CTL_RESET}};
      st_reg.stop_in_idle <= STATUS_RESET;
      st_reg.ladder_ctl   <= LADDER_RESET;
      st_reg.bus_state    <= BUS_IDLE;
      st_reg.rdata        <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  // wait one cycle, then answer; a frozen clock enable keeps it waiting
  assign avs_waitrequest_out = request & ((st_reg.bus_state != BUS_ANSWER) | ~ce_in);
  assign avs_readdata_out    = st_reg.rdata;

  // ----------------------------------------------------------------
  // reference ladder
  // ----------------------------------------------------------------
  assign ladder_enable_out            = st_reg.ladder_ctl[LADDER_EN_BIT];
  assign ladder_pin_output_enable_out = st_reg.ladder_ctl[LADDER_PIN_OE_BIT]
                                      & st_reg.ladder_ctl[LADDER_EN_BIT];
  assign ladder_range_select_out      = st_reg.ladder_ctl[LADDER_RANGE_BIT];
  assign ladder_source_select_out     = st_reg.ladder_ctl[LADDER_SRC_BIT];
  assign ladder_tap_value_out         = st_reg.ladder_ctl[LADDER_TAP_LSB+3:LADDER_TAP_LSB];

endmodule : cmpr_ctrl

// >>> testbench/cmpr_ctrl_asserts.sv
// port checker for the comparator and reference control block
module cmpr_ctrl_asserts (
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic [15:0] avs_address_in,
  input wire logic        avs_read_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [2:0]  cmp_enable_out,
  input wire logic [2:0]  comparator_output_pin_out,
  input wire logic [2:0]  comparator_output_pin_oe_out,
  input wire logic [2:0]  cmp_event_out,
  input wire logic        ladder_enable_out,
  input wire logic        ladder_pin_output_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import cmpr_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic rd_ok;
  assign rd_ok = avs_read_in && !avs_waitrequest_out;
  property p_oe_gate; (comparator_output_pin_oe_out & ~cmp_enable_out) == 3'h0; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("pin driven while off");
  property p_evt_gate; (cmp_event_out & ~$past(cmp_enable_out)) == 3'h0; endproperty
  a_evt_gate: assert property (p_evt_gate) else $error("event while off");
  property p_pin_off; (comparator_output_pin_out & ~$past(cmp_enable_out)) == 3'h0; endproperty
  a_pin_off: assert property (p_pin_off) else $error("level while off");
  property p_lad_oe; ladder_pin_output_enable_out |-> ladder_enable_out; endproperty
  a_lad_oe: assert property (p_lad_oe) else $error("ladder pin while down");
  property p_evt_chg;
    (cmp_event_out & ~(comparator_output_pin_out ^
      $past(comparator_output_pin_out))) == 3'h0;
  endproperty
  a_evt_chg: assert property (p_evt_chg) else $error("event without edge");
  property p_hi_zero; rd_ok |-> avs_readdata_out[31:16] == 16'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper half not zero");
  property p_odd_zero; rd_ok && avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0;
  endproperty
  a_odd_zero: assert property (p_odd_zero) else $error("odd read not zero");
  property p_stat;
    rd_ok && avs_address_in == STATUS_ADDR |->
      avs_readdata_out[2:0] == $past(comparator_output_pin_out);
  endproperty
  a_stat: assert property (p_stat) else $error("status copy wrong");
  c_event: cover property (cmp_event_out != 3'h0);
  c_stat: cover property (rd_ok && avs_address_in == STATUS_ADDR);
  c_lad: cover property (ladder_pin_output_enable_out);
endmodule : cmpr_ctrl_asserts

bind cmpr_ctrl cmpr_ctrl_asserts u_chk (
  .mclk_in(mclk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .cmp_enable_out(cmp_enable_out),
  .comparator_output_pin_out(comparator_output_pin_out),
  .comparator_output_pin_oe_out(comparator_output_pin_oe_out),
  .cmp_event_out(cmp_event_out), .ladder_enable_out(ladder_enable_out),
  .ladder_pin_output_enable_out(ladder_pin_output_enable_out)
);

// >>> testbench/cmpr_analog_model.sv
// behavioural model of the three analog comparator cores
module cmpr_analog_model (
  input  wire logic            mclk_in,
  input  wire logic [2:0]      cmp_enable_in,
  input  wire logic [2:0]      positive_input_select_in,
  input  wire logic [2:0][1:0] negative_input_select_in,
  input  wire logic [2:0][3:0] input_pins_in,
  input  wire logic            ladder_enable_in,
  input  wire logic            ladder_level_in,
  input  wire logic            absolute_ref_in,
  output logic      [2:0]      cmp_raw_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic chatter_reg = 1'b0;
  always @(posedge mclk_in) begin
    chatter_reg <= ~chatter_reg;
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      logic       p;
      logic [3:0] n;
      p = positive_input_select_in[i] ? ladder_enable_in & ladder_level_in
                                      : input_pins_in[i][0];
      n = {absolute_ref_in, input_pins_in[i][3:1]};
      // powered-down core output is meaningless
      cmp_raw_out[i] = cmp_enable_in[i] ? p & ~n[negative_input_select_in[i]] : chatter_reg;
    end
  end
endmodule : cmpr_analog_model

// >>> testbench/testbench.sv
// self-checking bench for the comparator and reference control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cmpr_pkg::*;
  localparam logic [15:0] LAD = LADDER_CTL_ADDR;
  localparam logic [15:0] STA = STATUS_ADDR;
  localparam logic [15:0] CM0 = CMP_CTL_ADDR0;
  logic            mclk_in  = 1'b0;
  logic            reset_in = 1'b1;
  logic            rd_r     = 1'b0;
  logic            wr_r     = 1'b0;
  logic            idle_r   = 1'b0;
  logic            lad_v    = 1'b0;
  logic            ce_r     = 1'b1;
  logic [3:0]      be_r     = 4'hf;
  logic [15:0]     addr     = 16'h0;
  logic [31:0]     wdat     = 32'h0;
  logic [2:0][3:0] pins     = 12'h0;
  logic [31:0]     rdo;
  logic [31:0]     rdat;
  logic            wreq;
  logic [2:0]      raw;
  logic [2:0]      en;
  logic [2:0]      psel;
  logic [2:0]      pin;
  logic [2:0]      oe;
  logic [2:0]      evt;
  logic [2:0][1:0] nsel;
  logic [7:0]      lad;
  int              ev_cnt     = 0;
  int              fail_count = 0;
  int              num_checks = 0;

  always #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (evt[0] === 1'b1) ev_cnt++;

  cmpr_ctrl u_dut (
    .mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce_r),
    .avs_address_in(addr), .avs_read_in(rd_r), .avs_write_in(wr_r),
    .avs_writedata_in(wdat), .avs_byteenable_in(be_r),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wreq), .idle_mode_in(idle_r),
    .cmp_raw_in(raw), .cmp_enable_out(en), .positive_input_select_out(psel),
    .negative_input_select_out(nsel), .comparator_output_pin_out(pin),
    .comparator_output_pin_oe_out(oe), .cmp_event_out(evt),
    .ladder_enable_out(lad[7]), .ladder_pin_output_enable_out(lad[6]),
    .ladder_range_select_out(lad[5]), .ladder_source_select_out(lad[4]),
    .ladder_tap_value_out(lad[3:0])
  );
  cmpr_analog_model u_ana (
    .mclk_in(mclk_in), .cmp_enable_in(en), .positive_input_select_in(psel),
    .negative_input_select_in(nsel), .input_pins_in(pins), .ladder_enable_in(lad[7]),
    .ladder_level_in(lad_v), .absolute_ref_in(1'b0), .cmp_raw_out(raw)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    addr <= a;
    wdat <= d;
    wr_r <= w;
    rd_r <= ~w;
    @(posedge mclk_in);
    while (wreq !== 1'b0) begin
      @(posedge mclk_in);
    end
    rdat = rdo;
    wr_r <= 1'b0;
    rd_r <= 1'b0;
    @(posedge mclk_in);
  endtask : bus

  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rchk

  task automatic t_reset;
    for (int i = 0; i < 3; i++) rchk(CM0 + 16'(16 * i), 32'hc3);
    rchk(STA, 32'h0);
    rchk(LAD, 32'h0);
    bus(1'b1, LAD, 32'hffff_ffff);
    rchk(LAD, 32'h807f);
    chk(lad, 8'hff);
    bus(1'b1, 16'ha030, 32'hffff);
    rchk(16'ha030, 32'h0);
    rchk(LAD + 16'h1, 32'h0);
  endtask : t_reset

  task automatic t_alias;
    bus(1'b1, LAD + 16'h4, 32'hffff);
    bus(1'b1, LAD + 16'h8, 32'h8005);
    rchk(LAD, 32'h8005);
    bus(1'b1, LAD + 16'h4, 32'h8001);
    rchk(LAD, 32'h4);
    bus(1'b1, LAD + 16'hc, 32'h6f);
    rchk(LAD, 32'h6b);
    chk(lad, 8'h2b);
    rchk(LAD + 16'h8, 32'h0);
  endtask : t_alias

  task automatic t_edges;
    logic [31:0] c;
    for (int v = 0; v < 2; v++) begin
      for (int m = 0; m < 4; m++) begin
        c = {16'h0, 2'h3, v[0], 5'h0, m[1:0], 6'h0};
        bus(1'b1, CM0, c);
        repeat (6) @(posedge mclk_in);
        ev_cnt = 0;
        chk({oe[0], pin[0]}, {1'b1, v[0]});
        pins[0][0] <= 1'b1;
        repeat (6) @(posedge mclk_in);
        chk(ev_cnt, m[v]);
        rchk(STA, {31'h0, ~v[0]});
        rchk(CM0, c | {23'h0, ~v[0], 8'h0});
        ev_cnt = 0;
        pins[0][0] <= 1'b0;
        repeat (6) @(posedge mclk_in);
        chk(ev_cnt, m[!v]);
      end
    end
  endtask : t_edges

  task automatic t_neg;
    pins[1] <= 4'hb;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, CM0 + 16'h10, 32'h8000 + 32'(k));
      repeat (6) @(posedge mclk_in);
      chk({nsel[1], pin[1]}, 32'(k * 2 + k % 2));
    end
    lad_v <= 1'b1;
    bus(1'b1, CM0 + 16'h10, 32'h8011);
    repeat (6) @(posedge mclk_in);
    chk(pin[1], 1'b0);
    bus(1'b1, LAD + 16'h8, 32'h8000);
    repeat (6) @(posedge mclk_in);
    chk({psel[1], pin[1]}, 2'h3);
  endtask : t_neg

  task automatic t_stop;
    pins[2] <= 4'h1;
    bus(1'b1, CM0 + 16'h20, 32'hc000);
    repeat (6) @(posedge mclk_in);
    chk({en[2], oe[2], pin[2]}, 3'h7);
    bus(1'b1, STA, 32'h2000);
    idle_r <= 1'b1;
    repeat (6) @(posedge mclk_in);
    chk({en, oe, pin}, 9'h0);
    rchk(STA, 32'h2000);
    bus(1'b1, STA + 16'h4, 32'h2000);
    repeat (6) @(posedge mclk_in);
    chk({en[2], pin[2]}, 2'h3);
    idle_r <= 1'b0;
    bus(1'b1, CM0 + 16'h24, 32'h8000);
    chk({en[2], oe[2]}, 2'h0);
    rchk(CM0 + 16'h20, 32'h4000);
    bus(1'b1, CM0 + 16'h28, 32'h8000);
    repeat (6) @(posedge mclk_in);
    rchk(CM0 + 16'h20, 32'hc100);
    rchk(STA, 32'h7);
  endtask : t_stop

  task automatic t_ce;
    ce_r    <= 1'b0;
    pins[2] <= 4'h0;
    fork
      bus(1'b1, LAD + 16'h4, 32'h8000);
      begin
        repeat (6) @(posedge mclk_in);
        chk({wreq, lad[7], pin[2]}, 3'h7);
        ce_r <= 1'b1;
      end
    join
    chk(lad[7], 1'b0);
    repeat (6) @(posedge mclk_in);
    chk(pin[2], 1'b0);
    be_r <= 4'h1;
    bus(1'b1, LAD, 32'hffff);
    be_r <= 4'hf;
    rchk(LAD, 32'h7f);
  endtask : t_ce

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (4000) @(posedge mclk_in);
    fail_count++;
    test_done;
  end

  initial begin
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    t_reset;
    t_alias;
    t_edges;
    t_neg;
    t_stop;
    t_ce;
    test_done;
  end
endmodule : testbench
